// ---- rtl/dpp_map.vh ----
// Constants for the diagnostic probe and global pin control block.
// Included by every design file of the block; holds definitions only.
`ifndef DPP_MAP_VH
`define DPP_MAP_VH

// Shared pad positions in the pad vectors
`define DPP_PAD_CNT        5
`define DPP_PAD_DIAGCLK    0
`define DPP_PAD_PROBE1     1
`define DPP_PAD_PROBE2     2
`define DPP_PAD_SERIAL     3
`define DPP_PAD_SETCLR     4

// User pad configurations
`define DPP_UMODE_W        2
`define DPP_UMODE_INPUT    2'h0
`define DPP_UMODE_OUTPUT   2'h1
`define DPP_UMODE_TRISTATE 2'h2
`define DPP_UMODE_BIDIR    2'h3

// Reset values
`define DPP_RST_BIT        1'h0
`define DPP_RST_OEN        1'h1

// Default probe node geometry
`define DPP_NODE_CNT       16
`define DPP_SEL_W          4

`endif

// ---- rtl/dpp_pad_cell.v ----
// One shared pad: user I/O buffer with its I/O registers, or a special role.
// Assumes one clock for all registers and that padIn is synchronous to it.
`timescale 1ns/1ns
`default_nettype none
`include "dpp_map.vh"

module dpp_pad_cell (
  input wire clock,                          // I/O register clock
  input wire arst_n,                         // Asynchronous reset, active low
  input wire padIn,                          // Level seen on the pad
  output reg padOut_ff,                      // Value driven onto the pad
  output reg padOeN_ff,                      // Output enable, low while driving
  output reg userIn_ff,                      // Captured pad input for user logic
  input wire userUsed,                       // Pad is used by the design
  input wire [`DPP_UMODE_W-1:0] userMode,    // User buffer configuration
  input wire userOut,                        // User output data
  input wire userOutEn,                      // User three-state enable, high drives
  input wire specialOn,                      // Pad is in its special role
  input wire specialIsOut,                   // Special role drives the pad
  input wire specialDrive,                   // Special output is allowed to drive
  input wire specialOut,                     // Special output data
  input wire regSetClr,                      // Global preset/clear of I/O registers
  input wire regSetVal                       // Value forced by preset/clear
);

  reg nxt_padOut;
  reg nxt_padOeN;
  reg nxt_userIn;

  always @* begin
    nxt_padOut = `DPP_RST_BIT;
    nxt_padOeN = `DPP_RST_OEN;
    nxt_userIn = `DPP_RST_BIT;
    if (specialOn) begin
      if (specialIsOut && specialDrive) begin
        nxt_padOut = specialOut;
        nxt_padOeN = 1'h0;
      end
    end else if (userUsed) begin
      case (userMode)
        `DPP_UMODE_INPUT: begin
          nxt_userIn = padIn;
        end
        `DPP_UMODE_OUTPUT: begin
          nxt_padOut = userOut;
          nxt_padOeN = 1'h0;
        end
        `DPP_UMODE_TRISTATE: begin
          nxt_padOut = userOut;
          nxt_padOeN = ~userOutEn;
        end
        `DPP_UMODE_BIDIR: begin
          nxt_padOut = userOut;
          nxt_padOeN = ~userOutEn;
          nxt_userIn = padIn;
        end
        default: begin
          nxt_padOeN = `DPP_RST_OEN;
        end
      endcase
      // Preset/clear reaches the data registers only, the enable stays put
      if (regSetClr) begin
        nxt_padOut = regSetVal;
        nxt_userIn = regSetVal;
      end
    end
    // Unused pads fall through with the enable high
  end

  // All I/O registers share the one I/O clock
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      padOut_ff <= `DPP_RST_BIT;
      padOeN_ff <= `DPP_RST_OEN;
      userIn_ff <= `DPP_RST_BIT;
    end else begin
      padOut_ff <= nxt_padOut;
      padOeN_ff <= nxt_padOeN;
      userIn_ff <= nxt_userIn;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/dpp_pin_control.v ----
// Top of the diagnostic probe and global pin control block: mode switching
// of the four shared diagnostic pads, probe selection and output, and the
// global I/O preset/clear pad. Assumes a single clock that serves as both
// array clock and I/O clock, and pad inputs synchronous to it.
`timescale 1ns/1ns
`default_nettype none
`include "dpp_map.vh"

// Behaviour
// - Mode high gives diag clock, both probes and serial input their diagnostic roles.
// - Mode low turns those four pads into ordinary user I/O pads.
// - In diagnostic mode the first probe drives the selected internal node value.
// - In diagnostic mode the second probe drives its own independently selected node.
// - Probe output can be disabled until the next reset; the probe pads stop driving one clock after the lock flag sets.
// - Serial diag input shifts selection data only while mode is high.
// - Global preset/clear input loads the data registers of used user pads at the next clock; enables are untouched.
// - Without preset/clear use, the preset/clear pad is an ordinary user pad.
// - Each user pad is input, output, three-state or bidirectional.
// - Unused user pads stay in high impedance.
// - The array clock clocks every sequential cell directly.
// - The I/O clock clocks every I/O register directly.
module dpp_pin_control #(
  parameter NODE_CNT = `DPP_NODE_CNT,        // Number of probeable internal nodes
  parameter SEL_W = `DPP_SEL_W               // Width of one node select field
) (
  input wire clock,                          // Array and I/O clock
  input wire arst_n,                         // Asynchronous reset, active low
  input wire modeSel,                        // Diagnostic mode select, high active
  input wire [`DPP_PAD_CNT-1:0] padIn,       // Levels seen on the shared pads
  output wire [`DPP_PAD_CNT-1:0] padOut,     // Values driven on the shared pads
  output wire [`DPP_PAD_CNT-1:0] padOeN,     // Pad output enables, low drives
  output wire [`DPP_PAD_CNT-1:0] userIn,     // Captured user inputs per pad
  input wire [`DPP_PAD_CNT-1:0] userUsed,    // Pad used by the design
  input wire [`DPP_PAD_CNT*`DPP_UMODE_W-1:0] userMode, // Per-pad user buffer mode
  input wire [`DPP_PAD_CNT-1:0] userOut,     // Per-pad user output data
  input wire [`DPP_PAD_CNT-1:0] userOutEn,   // Per-pad user three-state enable
  input wire [NODE_CNT-1:0] internalNodes,   // Internal design nodes to probe
  input wire probeDisableFuse,               // Request to disable probing until the next reset
  input wire ioSetClrUsed,                   // Design uses I/O preset/clear
  input wire ioSetClrPreset,                 // Preset/clear forces 1 when high, else 0
  output reg probeLocked_ff,                 // Probing disabled until the next reset
  output reg [SEL_W-1:0] probeSelFirst_ff,   // Node select of the first probe
  output reg [SEL_W-1:0] probeSelSecond_ff   // Node select of the second probe
);

  reg diagClkQ_ff;
  reg probeValFirst_ff;
  reg probeValSecond_ff;
  reg nxt_probeLocked;
  reg [SEL_W-1:0] nxt_probeSelFirst;
  reg [SEL_W-1:0] nxt_probeSelSecond;
  reg nxt_probeValFirst;
  reg nxt_probeValSecond;
  wire diagClkRise;
  wire setClrActive;
  wire [`DPP_PAD_CNT-1:0] specialOn;
  wire [`DPP_PAD_CNT-1:0] specialIsOut;
  wire [`DPP_PAD_CNT-1:0] specialOut;

  // Diag clock edges are only seen in diagnostic mode, so user traffic on
  // the pad cannot disturb the selection
  assign diagClkRise = modeSel && padIn[`DPP_PAD_DIAGCLK] && !diagClkQ_ff;
  // Pad levels are taken as synchronous; an asynchronous host clock would
  // need a synchroniser ahead of this block

  assign setClrActive = ioSetClrUsed && padIn[`DPP_PAD_SETCLR];

  // Diagnostic roles follow the mode pin; the preset/clear role follows ioSetClrUsed
  assign specialOn[`DPP_PAD_DIAGCLK] = modeSel;
  assign specialOn[`DPP_PAD_PROBE1] = modeSel;
  assign specialOn[`DPP_PAD_PROBE2] = modeSel;
  assign specialOn[`DPP_PAD_SERIAL] = modeSel;
  assign specialOn[`DPP_PAD_SETCLR] = ioSetClrUsed;

  assign specialIsOut[`DPP_PAD_DIAGCLK] = 1'h0;
  assign specialIsOut[`DPP_PAD_PROBE1] = 1'h1;
  assign specialIsOut[`DPP_PAD_PROBE2] = 1'h1;
  assign specialIsOut[`DPP_PAD_SERIAL] = 1'h0;
  assign specialIsOut[`DPP_PAD_SETCLR] = 1'h0;

  assign specialOut[`DPP_PAD_DIAGCLK] = `DPP_RST_BIT;
  assign specialOut[`DPP_PAD_PROBE1] = probeValFirst_ff;
  assign specialOut[`DPP_PAD_PROBE2] = probeValSecond_ff;
  assign specialOut[`DPP_PAD_SERIAL] = `DPP_RST_BIT;
  assign specialOut[`DPP_PAD_SETCLR] = `DPP_RST_BIT;

  always @* begin
    nxt_probeLocked = probeLocked_ff || probeDisableFuse;
    nxt_probeSelFirst = probeSelFirst_ff;
    nxt_probeSelSecond = probeSelSecond_ff;
    // Selection is one long shift chain: second field then first field
    if (diagClkRise) begin
      nxt_probeSelSecond = {probeSelSecond_ff[SEL_W-2:0], probeSelFirst_ff[SEL_W-1]};
      nxt_probeSelFirst = {probeSelFirst_ff[SEL_W-2:0], padIn[`DPP_PAD_SERIAL]};
    end
    // Out-of-range selects read zero rather than aliasing another node
    nxt_probeValFirst = `DPP_RST_BIT;
    nxt_probeValSecond = `DPP_RST_BIT;
    if (probeSelFirst_ff < NODE_CNT) begin
      nxt_probeValFirst = internalNodes[probeSelFirst_ff];
    end
    if (probeSelSecond_ff < NODE_CNT) begin
      nxt_probeValSecond = internalNodes[probeSelSecond_ff];
    end
    if (nxt_probeLocked) begin
      nxt_probeValFirst = `DPP_RST_BIT;
      nxt_probeValSecond = `DPP_RST_BIT;
    end
  end

  // Every sequential cell sits on the one array clock
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      diagClkQ_ff <= `DPP_RST_BIT;
      probeLocked_ff <= `DPP_RST_BIT;
      probeSelFirst_ff <= {SEL_W{1'h0}};
      probeSelSecond_ff <= {SEL_W{1'h0}};
      probeValFirst_ff <= `DPP_RST_BIT;
      probeValSecond_ff <= `DPP_RST_BIT;
    end else begin
      diagClkQ_ff <= padIn[`DPP_PAD_DIAGCLK];
      probeLocked_ff <= nxt_probeLocked;
      probeSelFirst_ff <= nxt_probeSelFirst;
      probeSelSecond_ff <= nxt_probeSelSecond;
      probeValFirst_ff <= nxt_probeValFirst;
      probeValSecond_ff <= nxt_probeValSecond;
    end
  end

  // Lock silences only the special drivers; user pads keep working
  wire specialDrive = ~probeLocked_ff;

  // One cell per shared pad; the cells differ only in their role wiring
  dpp_pad_cell uPadDiagClk (
    .clock(clock),
    .arst_n(arst_n),
    .padIn(padIn[`DPP_PAD_DIAGCLK]),
    .padOut_ff(padOut[`DPP_PAD_DIAGCLK]),
    .padOeN_ff(padOeN[`DPP_PAD_DIAGCLK]),
    .userIn_ff(userIn[`DPP_PAD_DIAGCLK]),
    .userUsed(userUsed[`DPP_PAD_DIAGCLK]),
    .userMode(userMode[`DPP_PAD_DIAGCLK*`DPP_UMODE_W +: `DPP_UMODE_W]),
    .userOut(userOut[`DPP_PAD_DIAGCLK]),
    .userOutEn(userOutEn[`DPP_PAD_DIAGCLK]),
    .specialOn(specialOn[`DPP_PAD_DIAGCLK]),
    .specialIsOut(specialIsOut[`DPP_PAD_DIAGCLK]),
    .specialDrive(specialDrive),
    .specialOut(specialOut[`DPP_PAD_DIAGCLK]),
    .regSetClr(setClrActive),
    .regSetVal(ioSetClrPreset)
  );

  dpp_pad_cell uPadProbeFirst (
    .clock(clock),
    .arst_n(arst_n),
    .padIn(padIn[`DPP_PAD_PROBE1]),
    .padOut_ff(padOut[`DPP_PAD_PROBE1]),
    .padOeN_ff(padOeN[`DPP_PAD_PROBE1]),
    .userIn_ff(userIn[`DPP_PAD_PROBE1]),
    .userUsed(userUsed[`DPP_PAD_PROBE1]),
    .userMode(userMode[`DPP_PAD_PROBE1*`DPP_UMODE_W +: `DPP_UMODE_W]),
    .userOut(userOut[`DPP_PAD_PROBE1]),
    .userOutEn(userOutEn[`DPP_PAD_PROBE1]),
    .specialOn(specialOn[`DPP_PAD_PROBE1]),
    .specialIsOut(specialIsOut[`DPP_PAD_PROBE1]),
    .specialDrive(specialDrive),
    .specialOut(specialOut[`DPP_PAD_PROBE1]),
    .regSetClr(setClrActive),
    .regSetVal(ioSetClrPreset)
  );

  dpp_pad_cell uPadProbeSecond (
    .clock(clock),
    .arst_n(arst_n),
    .padIn(padIn[`DPP_PAD_PROBE2]),
    .padOut_ff(padOut[`DPP_PAD_PROBE2]),
    .padOeN_ff(padOeN[`DPP_PAD_PROBE2]),
    .userIn_ff(userIn[`DPP_PAD_PROBE2]),
    .userUsed(userUsed[`DPP_PAD_PROBE2]),
    .userMode(userMode[`DPP_PAD_PROBE2*`DPP_UMODE_W +: `DPP_UMODE_W]),
    .userOut(userOut[`DPP_PAD_PROBE2]),
    .userOutEn(userOutEn[`DPP_PAD_PROBE2]),
    .specialOn(specialOn[`DPP_PAD_PROBE2]),
    .specialIsOut(specialIsOut[`DPP_PAD_PROBE2]),
    .specialDrive(specialDrive),
    .specialOut(specialOut[`DPP_PAD_PROBE2]),
    .regSetClr(setClrActive),
    .regSetVal(ioSetClrPreset)
  );

  dpp_pad_cell uPadSerial (
    .clock(clock),
    .arst_n(arst_n),
    .padIn(padIn[`DPP_PAD_SERIAL]),
    .padOut_ff(padOut[`DPP_PAD_SERIAL]),
    .padOeN_ff(padOeN[`DPP_PAD_SERIAL]),
    .userIn_ff(userIn[`DPP_PAD_SERIAL]),
    .userUsed(userUsed[`DPP_PAD_SERIAL]),
    .userMode(userMode[`DPP_PAD_SERIAL*`DPP_UMODE_W +: `DPP_UMODE_W]),
    .userOut(userOut[`DPP_PAD_SERIAL]),
    .userOutEn(userOutEn[`DPP_PAD_SERIAL]),
    .specialOn(specialOn[`DPP_PAD_SERIAL]),
    .specialIsOut(specialIsOut[`DPP_PAD_SERIAL]),
    .specialDrive(specialDrive),
    .specialOut(specialOut[`DPP_PAD_SERIAL]),
    .regSetClr(setClrActive),
    .regSetVal(ioSetClrPreset)
  );

  dpp_pad_cell uPadSetClr (
    .clock(clock),
    .arst_n(arst_n),
    .padIn(padIn[`DPP_PAD_SETCLR]),
    .padOut_ff(padOut[`DPP_PAD_SETCLR]),
    .padOeN_ff(padOeN[`DPP_PAD_SETCLR]),
    .userIn_ff(userIn[`DPP_PAD_SETCLR]),
    .userUsed(userUsed[`DPP_PAD_SETCLR]),
    .userMode(userMode[`DPP_PAD_SETCLR*`DPP_UMODE_W +: `DPP_UMODE_W]),
    .userOut(userOut[`DPP_PAD_SETCLR]),
    .userOutEn(userOutEn[`DPP_PAD_SETCLR]),
    .specialOn(specialOn[`DPP_PAD_SETCLR]),
    .specialIsOut(specialIsOut[`DPP_PAD_SETCLR]),
    .specialDrive(specialDrive),
    .specialOut(specialOut[`DPP_PAD_SETCLR]),
    .regSetClr(setClrActive),
    .regSetVal(ioSetClrPreset)
  );

endmodule
`default_nettype wire

// ---- verification/dpp_pin_control_chk.sv ----
// Checker: pad, probe and selection timing at the block's ports.
// Assumes one clock and an async active-low reset; bound below.
`timescale 1ns/1ns
`default_nettype none
module dpp_pin_control_chk #(
  parameter NODE_CNT = 16, // Probeable nodes
  parameter SEL_W = 4 // Select width
) (
  input wire clock, // Clock
  input wire arst_n, // Reset
  input wire modeSel, // Mode
  input wire [4:0] padIn, // Pad levels
  input wire [4:0] padOut, // Pad drive
  input wire [4:0] padOeN, // Enables
  input wire [4:0] userIn, // User inputs
  input wire [4:0] userUsed, // Used pads
  input wire [9:0] userMode, // Pad modes
  input wire [4:0] userOut, // User data
  input wire [NODE_CNT-1:0] internalNodes, // Nodes
  input wire probeDisableFuse, // Lock request
  input wire ioSetClrUsed, // Set/clear used
  input wire ioSetClrPreset, // Set/clear value
  input wire probeLocked_ff, // Locked
  input wire [SEL_W-1:0] probeSelFirst_ff, // First select
  input wire [SEL_W-1:0] probeSelSecond_ff // Second select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire setClr = ioSetClrUsed && padIn[4];
  property p_diagRole; $past(modeSel) |-> padOeN[0] && padOeN[3] && !userIn[3]; endproperty
  a_diagRole: assert property (p_diagRole) else $error("diag pads still user pads");
  property p_userOut; !modeSel && !setClr && userUsed[1] && userMode[3:2] == 2'h1
    |=> !padOeN[1] && padOut[1] == $past(userOut[1]); endproperty
  a_userOut: assert property (p_userOut) else $error("user output pad wrong");
  property p_unused; !ioSetClrUsed && !userUsed[4] |=> padOeN[4] && !userIn[4]; endproperty
  a_unused: assert property (p_unused) else $error("unused pad not hi-z");
  property p_setClr; !modeSel && setClr && userUsed[2] && userMode[5:4] == 2'h1
    |=> padOut[2] == $past(ioSetClrPreset); endproperty
  a_setClr: assert property (p_setClr) else $error("preset/clear not applied");
  property p_probeA; $past(modeSel, 2) && $past(modeSel) && !probeLocked_ff && !$past(probeLocked_ff, 2)
    |-> !padOeN[1] && padOut[1] == $past(internalNodes[probeSelFirst_ff], 2); endproperty
  a_probeA: assert property (p_probeA) else $error("first probe wrong");
  property p_probeB; $past(modeSel, 2) && $past(modeSel) && !probeLocked_ff && !$past(probeLocked_ff, 2)
    |-> !padOeN[2] && padOut[2] == $past(internalNodes[probeSelSecond_ff], 2); endproperty
  a_probeB: assert property (p_probeB) else $error("second probe wrong");
  property p_lock; probeDisableFuse || probeLocked_ff
    |=> probeLocked_ff ##1 (!$past(modeSel) || padOeN[1] && padOeN[2]); endproperty
  a_lock: assert property (p_lock) else $error("probe lock failed");
  property p_noShift; !modeSel |=> $stable(probeSelFirst_ff) && $stable(probeSelSecond_ff); endproperty
  a_noShift: assert property (p_noShift) else $error("select moved in user mode");
  property p_shift; modeSel && padIn[0] && !$past(padIn[0]) |=> probeSelSecond_ff[0] == $past(probeSelFirst_ff[3])
    && probeSelFirst_ff == {$past(probeSelFirst_ff[2:0]), $past(padIn[3])}; endproperty
  a_shift: assert property (p_shift) else $error("select shift wrong");
  c_shift: cover property (modeSel && padIn[0] && !$past(padIn[0]));
  c_setClr: cover property (!modeSel && setClr);
  c_lock: cover property (modeSel && probeLocked_ff);
endmodule
bind dpp_pin_control dpp_pin_control_chk #(.NODE_CNT(NODE_CNT), .SEL_W(SEL_W)) u_dpp_pin_control_chk (
  .clock(clock), .arst_n(arst_n), .modeSel(modeSel), .padIn(padIn), .padOut(padOut), .padOeN(padOeN),
  .userIn(userIn), .userUsed(userUsed), .userMode(userMode), .userOut(userOut), .internalNodes(internalNodes),
  .probeDisableFuse(probeDisableFuse), .ioSetClrUsed(ioSetClrUsed), .ioSetClrPreset(ioSetClrPreset),
  .probeLocked_ff(probeLocked_ff), .probeSelFirst_ff(probeSelFirst_ff), .probeSelSecond_ff(probeSelSecond_ff));
`default_nettype wire

// ---- verification/dpp_debug_host.sv ----
// Debug host model: shifts probe selections in over the diag clock pad.
// Driven by task calls from the bench; shares the block's clock.
`timescale 1ns/1ns
`default_nettype none
module dpp_debug_host (
  input wire clock, // Bench clock
  output var logic diagClk, // Diag clock pad
  output var logic serialDiag // Serial diag pad
);
  initial begin
    diagClk = 1'b0;
    serialDiag = 1'b0;
  end
  // Data is set while the diag clock is low, so it is steady at its rise
  task automatic shift(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock);
      diagClk <= 1'b0;
      serialDiag <= w[i];
      @(posedge clock);
      diagClk <= 1'b1;
    end
    @(posedge clock);
    diagClk <= 1'b0;
    // Undriven data line between frames: show the inverse, not the last bit
    serialDiag <= ~w[0];
  endtask
endmodule
`default_nettype wire

// ---- verification/dpp_pin_control_tb.sv ----
// Testbench: user pad modes, preset/clear, probing, refused shifts, lock.
// The debug host model drives the diag clock and serial pads.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("Error %0t: bad value", $time); end end
module dpp_pin_control_tb;
  logic clock, arst_n, modeSel, fuse, scUsed, scPre, smp;
  logic [4:0] raw, used, uo, uoe;
  logic [9:0] md;
  logic [15:0] nodes, n;
  logic [3:0] a, b;
  logic [29:0] e;
  logic [29:0] q[$];
  int n_fail = 0;
  int checks = 0;
  wire dc, sd, locked;
  wire [4:0] padOut, padOeN, userIn;
  wire [3:0] selA, selB;
  wire [4:0] padIn = {raw[4], sd, raw[2:1], dc};
  dpp_debug_host u_dpp_debug_host (.clock(clock), .diagClk(dc), .serialDiag(sd));
  dpp_pin_control u_dpp_pin_control (.clock(clock), .arst_n(arst_n), .modeSel(modeSel), .padIn(padIn),
    .padOut(padOut), .padOeN(padOeN), .userIn(userIn), .userUsed(used), .userMode(md), .userOut(uo),
    .userOutEn(uoe), .internalNodes(nodes), .probeDisableFuse(fuse), .ioSetClrUsed(scUsed),
    .ioSetClrPreset(scPre), .probeLocked_ff(locked), .probeSelFirst_ff(selA), .probeSelSecond_ff(selB));
  // Note is {mask, value} over {userIn, padOeN, padOut}
  always @(posedge clock) if (smp) begin
    e = q.pop_front();
    `CHK({userIn, padOeN, padOut} & e[29:15], e[14:0])
  end
  task automatic expect_(input logic [29:0] me, input int lat);
    q.push_back(me);
    repeat (lat) @(posedge clock);
    smp <= 1'b1;
    @(posedge clock);
    smp <= 1'b0;
  endtask
  function automatic logic [29:0] expU(input logic [4:0] pin);
    logic [4:0] drv, rd;
    for (int i = 0; i < 5; i++) begin
      drv[i] = used[i] && (md[2*i+:2] == 2'h1 || (md[2*i+1] && uoe[i]));
      rd[i] = used[i] && (md[2*i+:2] == 2'h0 || md[2*i+:2] == 2'h3);
    end
    return {5'h1F, 5'h1F, drv, rd & pin, ~drv, drv & uo};
  endfunction
  task automatic end_sim;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    {arst_n, modeSel, fuse, scUsed, scPre, smp} = 6'h00;
    {raw, used, uo, uoe, md, nodes} = '0;
    void'($urandom(20));
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (24) begin
      @(posedge clock);
      {raw, used, uo, uoe} <= 20'($urandom);
      md <= 10'($urandom);
      @(negedge clock);
      expect_(expU(padIn), 1);
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge clock);
      {used, md, raw[4], scUsed, scPre} <= {5'h1F, 10'h155, 1'b1, 1'b1, p[0]};
      @(negedge clock);
      expect_({15'h7FEF, 1'b0, {4{p[0]}}, 5'h10, 1'b0, {4{p[0]}}}, 1);
    end
    @(posedge clock);
    {scUsed, raw[4], modeSel} <= 3'h1;
    repeat (4) begin
      {a, b} = 8'($urandom);
      u_dpp_debug_host.shift({b, a});
      n = 16'($urandom);
      nodes <= n;
      @(negedge clock);
      `CHK({selB, selA}, {b, a})
      expect_({15'h27E6, 5'h00, 5'h09, 2'b00, n[b], n[a], 1'b0}, 2);
    end
    @(posedge clock);
    modeSel <= 1'b0;
    u_dpp_debug_host.shift(8'($urandom));
    @(negedge clock);
    `CHK({selB, selA}, {b, a})
    @(posedge clock);
    {modeSel, fuse} <= 2'h3;
    @(posedge clock);
    fuse <= 1'b0;
    @(negedge clock);
    `CHK(locked, 1'b1)
    expect_({15'h00C0, 15'h00C0}, 1);
    end_sim();
  end
endmodule
`default_nettype wire
